// >>> rtl/ecm_pkg.sv
// shared constants, register map and types of the event counter monitor
package ecm_pkg;

    // ------------------------------------------------------------------
    // register map, byte addresses in the low address byte
    // ------------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFS_GLOBAL = 8'h00;
    localparam logic [7:0] OFS_PSW = 8'h04;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h08;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h0C;
    localparam logic [7:0] OFS_INFO_MASK = 8'h10;
    localparam logic [7:0] OFS_INFO_SIZE = 8'h14;
    localparam logic [7:0] OFS_CTL_BASE = 8'h20;
    localparam logic [7:0] OFS_CNT_BASE = 8'h40;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int GLOBAL_FREEZE_BIT = 0;
    localparam int PSW_UP_BIT = 0;
    localparam int PSW_PP_BIT = 1;
    localparam int PSW_SP_BIT = 2;
    localparam int CTL_SEL_LSB = 0;
    localparam int CTL_SEL_W = 8;
    localparam int CTL_PRIV_BIT = 8;
    localparam int CTL_OVF_IE_BIT = 9;
    localparam int CTL_W = 10;
    localparam int INFO_CNT_MASK_LSB = 8;
    localparam int INFO_WIDTH_LSB = 8;
    localparam int FIRST_PAIR = 4;
    localparam logic [1:0] CPL_ZERO = 2'h0;

    // ------------------------------------------------------------------
    // values after reset
    // ------------------------------------------------------------------
    localparam logic FREEZE_RESET = 1'b0;
    localparam logic [2:0] PSW_RESET = 3'h0;
    localparam logic [CTL_W-1:0] CTL_RESET = 10'h000;
    localparam logic [31:0] CNT_RESET = 32'h0000_0000;
    localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_WRITE,
        ST_READ_WAIT,
        ST_READ_DONE
    } bus_state_t;

endpackage : ecm_pkg

// >>> rtl/counter_slice.sv
// one event count register with increment, load and wrap detection
`timescale 1ns/100ps
module counter_slice #(
    parameter int WIDTH = 32
) (
    input wire logic hclk, // core clock
    input wire logic hresetn, // async reset, active low
    input wire logic load, // software write this cycle
    input wire logic [WIDTH-1:0] load_value, // value written
    input wire logic inc, // qualified event this cycle
    output logic [WIDTH-1:0] count, // current count
    output logic wrap // pulse: count passes its maximum
);
    import ecm_pkg::*;

    logic [WIDTH-1:0] next_count;

    // a software write wins over a coincident event, which is then lost
    always_comb begin
        next_count = count;
        if (load) begin
            next_count = load_value;
        end else if (inc) begin
            next_count = WIDTH'(count + 1'b1);
        end
    end

    assign wrap = inc && !load && (count == {WIDTH{1'b1}});

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count <= WIDTH'(CNT_RESET);
        end else begin
            count <= next_count;
        end
    end

endmodule : counter_slice

// >>> rtl/event_counter_monitor.sv
// event counter monitor: generic counter pairs behind an AHB-Lite slave
//
// Notes on behaviour
// - at least four counter pairs, numbered four to seven, control plus count
// - control register selects the event and its counting qualification
// - count register holds the tally of the selected event
// - control and count writes take effect only at privilege level zero
// - privileged-select bit marks a counter privileged or user level
// - privileged counters read only at privilege level zero
// - user counters readable by user code unless secure read block set
// - user counters count only while user monitor enable is set
// - privileged counters count only while privileged monitor enable is set
// - freeze control at zero stops every counter
// - freeze control at one: count per select bit and enables
// - each counter can raise an overflow interrupt
// - info registers give implemented masks, pair count and counter width
//
// Implementation choices: the AHB-Lite slave port and the register offsets.
`timescale 1ns/100ps
module event_counter_monitor #(
    parameter int NUM_PAIRS = 4,
    parameter int CTR_WIDTH = 32,
    parameter int NUM_EVENTS = 16
) (
    input wire logic hclk, // core clock, 100 MHz
    input wire logic hresetn, // async reset, active low
    input wire logic hsel, // slave select
    input wire logic [31:0] haddr, // byte address
    input wire logic [1:0] htrans, // transfer type
    input wire logic hwrite, // write when high
    input wire logic [2:0] hsize, // transfer size, word only
    input wire logic [31:0] hwdata, // write data
    input wire logic hready, // bus ready in
    output logic hreadyout, // slave ready
    output logic [31:0] hrdata, // read data
    output logic hresp, // always OKAY
    input wire logic [1:0] current_privilege_level, // level of the accessing code
    input wire logic [NUM_EVENTS-1:0] event_in, // processor events, core clock
    output logic overflow_irq // level interrupt
);
    import ecm_pkg::*;

    localparam int EV_IDX_W = $clog2(NUM_EVENTS);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    bus_state_t state, next_state;
    logic [ADDR_W-1:0] a_addr, next_a_addr;
    logic [31:0] next_hrdata;
    logic freeze_control, next_freeze_control;
    logic user_monitor_enable, next_user_monitor_enable;
    logic privileged_monitor_enable, next_privileged_monitor_enable;
    logic secure_monitor_read_block, next_secure_monitor_read_block;
    logic [NUM_PAIRS-1:0] irq_status, next_irq_status;
    logic [NUM_PAIRS-1:0] irq_mask, next_irq_mask;
    logic [CTL_W-1:0] event_control_reg [NUM_PAIRS];
    logic [CTL_W-1:0] next_event_control_reg [NUM_PAIRS];
    logic [CTR_WIDTH-1:0] event_count_reg [NUM_PAIRS];
    logic [NUM_PAIRS-1:0] cnt_wr, count_en, evt, inc, wrap;
    logic accept, wr_go, is_priv;

    // ------------------------------------------------------------------
    // decode
    // ------------------------------------------------------------------
    function automatic logic slot_hit(input logic [ADDR_W-1:0] addr,
                                      input logic [ADDR_W-1:0] base, input int idx);
        slot_hit = (addr == ADDR_W'(base + ADDR_W'(idx * 4)));
    endfunction : slot_hit

    function automatic logic [7:0] impl_mask(input int first, input int n);
        logic [7:0] m;
        m = '0;
        for (int k = 0; k < n; k++) begin
            m[first + k] = 1'b1;
        end
        impl_mask = m;
    endfunction : impl_mask

    assign accept = hsel && hready && htrans[1];
    assign wr_go = (state == ST_WRITE);
    assign is_priv = (current_privilege_level == CPL_ZERO);
    assign hreadyout = (state != ST_READ_WAIT);
    assign hresp = 1'b0;
    assign overflow_irq = |(irq_status & irq_mask);

    // ------------------------------------------------------------------
    // counter pairs
    // ------------------------------------------------------------------
    for (genvar i = 0; i < NUM_PAIRS; i++) begin : g_pair
        logic [CTL_SEL_W-1:0] sel;
        assign sel = event_control_reg[i][CTL_SEL_LSB +: CTL_SEL_W];
        assign cnt_wr[i] = wr_go && is_priv && slot_hit(a_addr, OFS_CNT_BASE, i);
        // out-of-range event selects count nothing
        assign evt[i] = (32'(sel) < NUM_EVENTS) ? event_in[sel[EV_IDX_W-1:0]] : 1'b0;
        assign count_en[i] = freeze_control && (event_control_reg[i][CTL_PRIV_BIT] ?
            privileged_monitor_enable : user_monitor_enable);
        assign inc[i] = count_en[i] && evt[i];

        counter_slice #(
            .WIDTH(CTR_WIDTH)
        ) u_slice (
            .hclk(hclk),
            .hresetn(hresetn),
            .load(cnt_wr[i]),
            .load_value(hwdata[CTR_WIDTH-1:0]),
            .inc(inc[i]),
            .count(event_count_reg[i]),
            .wrap(wrap[i])
        );
    end

    // ------------------------------------------------------------------
    // bus and register file
    // ------------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_a_addr = a_addr;
        next_hrdata = hrdata;
        next_freeze_control = freeze_control;
        next_user_monitor_enable = user_monitor_enable;
        next_privileged_monitor_enable = privileged_monitor_enable;
        next_secure_monitor_read_block = secure_monitor_read_block;
        next_irq_mask = irq_mask;
        next_irq_status = irq_status;
        for (int k = 0; k < NUM_PAIRS; k++) begin
            next_event_control_reg[k] = event_control_reg[k];
        end
        // write data phase
        if (wr_go) begin
            if (a_addr == OFS_PSW) begin
                // user level may toggle only the user enable
                next_user_monitor_enable = hwdata[PSW_UP_BIT];
                if (is_priv) begin
                    next_privileged_monitor_enable = hwdata[PSW_PP_BIT];
                    next_secure_monitor_read_block = hwdata[PSW_SP_BIT];
                end
            end
            if (is_priv) begin
                if (a_addr == OFS_GLOBAL) begin
                    next_freeze_control = hwdata[GLOBAL_FREEZE_BIT];
                end
                if (a_addr == OFS_IRQ_MASK) begin
                    next_irq_mask = hwdata[NUM_PAIRS-1:0];
                end
                if (a_addr == OFS_IRQ_STATUS) begin
                    next_irq_status = irq_status & ~hwdata[NUM_PAIRS-1:0];
                end
                for (int k = 0; k < NUM_PAIRS; k++) begin
                    if (slot_hit(a_addr, OFS_CTL_BASE, k)) begin
                        next_event_control_reg[k] = hwdata[CTL_W-1:0];
                    end
                end
            end
        end
        // a new overflow wins over a clear in the same cycle
        next_irq_status = next_irq_status | (wrap & {
            NUM_PAIRS{1'b1}} & ovf_ie_vec());
        // bus sequencing
        case (state)
            ST_READ_WAIT: begin
                next_state = ST_READ_DONE;
                next_hrdata = read_value(a_addr);
            end
            default: begin
                if (accept) begin
                    next_state = hwrite ? ST_WRITE : ST_READ_WAIT;
                    next_a_addr = haddr[ADDR_W-1:0];
                end else begin
                    next_state = ST_IDLE;
                end
            end
        endcase
    end

    function automatic logic [NUM_PAIRS-1:0] ovf_ie_vec();
        logic [NUM_PAIRS-1:0] v;
        for (int k = 0; k < NUM_PAIRS; k++) begin
            v[k] = event_control_reg[k][CTL_OVF_IE_BIT];
        end
        ovf_ie_vec = v;
    endfunction : ovf_ie_vec

    // refused reads complete normally and return zero
    function automatic logic [31:0] read_value(input logic [ADDR_W-1:0] addr);
        logic [31:0] v;
        v = '0;
        case (addr)
            OFS_GLOBAL: v[GLOBAL_FREEZE_BIT] = freeze_control;
            OFS_PSW: v[PSW_SP_BIT:PSW_UP_BIT] = {secure_monitor_read_block,
                privileged_monitor_enable, user_monitor_enable};
            OFS_IRQ_STATUS: v[NUM_PAIRS-1:0] = irq_status;
            OFS_IRQ_MASK: v[NUM_PAIRS-1:0] = irq_mask;
            OFS_INFO_MASK: v[15:0] = {impl_mask(FIRST_PAIR, NUM_PAIRS),
                impl_mask(FIRST_PAIR, NUM_PAIRS) | 8'h01};
            OFS_INFO_SIZE: v[15:0] = {8'(CTR_WIDTH), 8'(NUM_PAIRS)};
            default: begin
                for (int k = 0; k < NUM_PAIRS; k++) begin
                    if (slot_hit(addr, OFS_CTL_BASE, k)) begin
                        v[CTL_W-1:0] = event_control_reg[k];
                    end
                    if (slot_hit(addr, OFS_CNT_BASE, k) && (is_priv ||
                        (!event_control_reg[k][CTL_PRIV_BIT] && !secure_monitor_read_block))) begin
                        v[CTR_WIDTH-1:0] = event_count_reg[k];
                    end
                end
            end
        endcase
        read_value = v;
    endfunction : read_value

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= ST_IDLE;
            a_addr <= '0;
            hrdata <= RDATA_RESET;
            freeze_control <= FREEZE_RESET;
            user_monitor_enable <= PSW_RESET[PSW_UP_BIT];
            privileged_monitor_enable <= PSW_RESET[PSW_PP_BIT];
            secure_monitor_read_block <= PSW_RESET[PSW_SP_BIT];
            irq_status <= '0;
            irq_mask <= '0;
            for (int k = 0; k < NUM_PAIRS; k++) begin
                event_control_reg[k] <= CTL_RESET;
            end
        end else begin
            state <= next_state;
            a_addr <= next_a_addr;
            hrdata <= next_hrdata;
            freeze_control <= next_freeze_control;
            user_monitor_enable <= next_user_monitor_enable;
            privileged_monitor_enable <= next_privileged_monitor_enable;
            secure_monitor_read_block <= next_secure_monitor_read_block;
            irq_status <= next_irq_status;
            irq_mask <= next_irq_mask;
            for (int k = 0; k < NUM_PAIRS; k++) begin
                event_control_reg[k] <= next_event_control_reg[k];
            end
        end
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_read_one_wait: assert property ((state == ST_READ_WAIT) |-> !hreadyout ##1 hreadyout)
        else $error("read did not complete after one wait state");
    a_info_size: assert property ((state == ST_READ_WAIT) && (a_addr == OFS_INFO_SIZE)
        |=> hrdata[7:0] == 8'(NUM_PAIRS) && hrdata[15:8] == 8'(CTR_WIDTH))
        else $error("info register shows wrong size");
    a_write_no_wait: assert property ((state == ST_WRITE) |-> hreadyout)
        else $error("write data phase was stretched");
    a_psw_user_keep: assert property (wr_go && !is_priv && (a_addr == OFS_PSW) |=>
        $stable(privileged_monitor_enable) && $stable(secure_monitor_read_block))
        else $error("unprivileged write changed privileged status bits");
    a_freeze_guard: assert property (wr_go && !is_priv && (a_addr == OFS_GLOBAL)
        |=> $stable(freeze_control))
        else $error("freeze control changed by unprivileged write");

    for (genvar i = 0; i < NUM_PAIRS; i++) begin : g_chk
        a_ctl_write_priv: assert property (wr_go && !is_priv &&
            slot_hit(a_addr, OFS_CTL_BASE, i) |=> $stable(event_control_reg[i]))
            else $error("control register changed by unprivileged write");
        a_freeze_stops: assert property (!freeze_control && !cnt_wr[i]
            |=> $stable(event_count_reg[i]))
            else $error("counter moved while frozen");
        a_user_count: assert property (freeze_control && !event_control_reg[i][CTL_PRIV_BIT] &&
            user_monitor_enable && evt[i] && !cnt_wr[i] && event_count_reg[i] != '1
            |=> event_count_reg[i] == CTR_WIDTH'($past(event_count_reg[i]) + 1'b1))
            else $error("enabled user counter did not step");
        a_priv_gate: assert property (event_control_reg[i][CTL_PRIV_BIT] &&
            !privileged_monitor_enable && !cnt_wr[i] |=> $stable(event_count_reg[i]))
            else $error("privileged counter counted while disabled");
        a_wrap_flag: assert property (inc[i] && !cnt_wr[i] && event_count_reg[i] == '1 &&
            event_control_reg[i][CTL_OVF_IE_BIT] |=> event_count_reg[i] == '0 && irq_status[i])
            else $error("wrap did not clear counter and flag overflow");
        a_priv_read: assert property ((state == ST_READ_WAIT) && !is_priv &&
            event_control_reg[i][CTL_PRIV_BIT] && slot_hit(a_addr, OFS_CNT_BASE, i)
            |=> hrdata == 32'h0000_0000)
            else $error("privileged counter read at user level");
        a_secure_block: assert property ((state == ST_READ_WAIT) && !is_priv &&
            secure_monitor_read_block && slot_hit(a_addr, OFS_CNT_BASE, i)
            |=> hrdata == 32'h0000_0000)
            else $error("user read not blocked by secure bit");
        a_count_read: assert property ((state == ST_READ_WAIT) && is_priv &&
            slot_hit(a_addr, OFS_CNT_BASE, i) |=> hrdata == 32'($past(event_count_reg[i])))
            else $error("count read returned wrong value");
        a_irq_level: assert property (irq_status[i] && irq_mask[i] |-> overflow_irq)
            else $error("unmasked overflow not on interrupt");
        // selects beyond the event bus must never reach a counter
        a_sel_range: assert property ((event_control_reg[i][CTL_SEL_LSB +: CTL_SEL_W] >=
            CTL_SEL_W'(NUM_EVENTS)) |-> !evt[i])
            else $error("out of range event select produced a count");
    end

    c_irq_rise: cover property (!overflow_irq ##1 overflow_irq);
    c_read_done: cover property ((state == ST_READ_WAIT) ##1 (state == ST_READ_DONE));
    c_wrap: cover property (|wrap);
    c_user_blocked: cover property (!is_priv && secure_monitor_read_block && (state == ST_READ_WAIT));

endmodule : event_counter_monitor

// >>> bench/event_counter_monitor_tb.sv
// self-checking bench of the event counter monitor driven over AHB-Lite
`timescale 1ns/100ps
module event_counter_monitor_tb;
    import ecm_pkg::*;
    // ------------------------------------------------------------------
    // signals
    // ------------------------------------------------------------------
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h0;
    logic [31:0] hwdata = 32'h0000_0000;
    logic hreadyout;
    logic [31:0] hrdata;
    logic hresp;
    logic [1:0] cpl = 2'h0;
    logic [15:0] event_in = 16'h0000;
    logic overflow_irq;
    int failures = 0;
    int checks_done = 0;
    logic [31:0] lfsr = 32'h0001_7D3A;
    logic [31:0] rd;
    logic [31:0] exp4;
    logic [31:0] exp5;
    logic [31:0] cv;
    logic frz = 1'b0;
    logic up = 1'b0;
    logic pp = 1'b0;

    // single slave: its own ready closes the loop as the bus ready
    event_counter_monitor dut_u (
        .hclk(hclk),
        .hresetn(hresetn),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hwdata(hwdata),
        .hready(hreadyout),
        .hreadyout(hreadyout),
        .hrdata(hrdata),
        .hresp(hresp),
        .current_privilege_level(cpl),
        .event_in(event_in),
        .overflow_irq(overflow_irq)
    );

    always #5 hclk = ~hclk;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] step(input logic [31:0] v);
        return v[0] ? ((v >> 1) ^ 32'h8020_0003) : (v >> 1);
    endfunction : step

    function automatic logic [31:0] counts(input logic f, input logic pm, input logic ev);
        return {31'h0000_0000, f & (pm ? pp : up) & ev};
    endfunction : counts

    task conclude;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : conclude

    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // ready is looked at mid-cycle, so the following rising edge is the one it qualifies
    task wait_rdy;
        int k;
        k = 0;
        @(negedge hclk);
        while (hreadyout !== 1'b1 && k < 50) begin
            @(negedge hclk);
            k++;
        end
        if (k >= 50) begin
            failures++;
        end
    endtask : wait_rdy

    task bus(input logic w, input logic [7:0] a, input logic [31:0] wd, input logic [1:0] lvl);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        hsize <= 3'h2;
        haddr <= {24'h00_0000, a};
        cpl <= lvl;
        wait_rdy();
        @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= w ? wd : 32'h0000_0000;
        wait_rdy();
        rd = hrdata;
    endtask : bus

    task wr(input logic [7:0] a, input logic [31:0] wd, input logic [1:0] lvl);
        bus(1'b1, a, wd, lvl);
    endtask : wr

    task rchk(input string n, input logic [7:0] a, input logic [1:0] lvl, input logic [31:0] e);
        bus(1'b0, a, 32'h0000_0000, lvl);
        check(n, rd, e);
    endtask : rchk

    task irq_chk(input logic e);
        repeat (2) @(negedge hclk);
        check("overflow_irq", {31'h0000_0000, overflow_irq}, {31'h0000_0000, e});
    endtask : irq_chk

    // pair four counts event 3 as a user counter, pair five event 5 as privileged
    task run_events(input int n);
        repeat (n) begin
            @(posedge hclk);
            lfsr = step(lfsr);
            event_in <= lfsr[15:0];
            exp4 = exp4 + counts(frz, 1'b0, lfsr[3]);
            exp5 = exp5 + counts(frz, 1'b1, lfsr[5]);
        end
        @(posedge hclk);
        event_in <= 16'h0000;
    endtask : run_events

    initial begin
        #100000;
        failures++;
        conclude();
    end

    // ------------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        irq_chk(1'b0);
        rchk("global", OFS_GLOBAL, 2'h0, 32'h0000_0000);
        rchk("psw", OFS_PSW, 2'h0, 32'h0000_0000);
        rchk("ctl4 reset", OFS_CTL_BASE, 2'h0, 32'h0000_0000);
        rchk("info mask", OFS_INFO_MASK, 2'h0, 32'h0000_F0F1);
        rchk("info size", OFS_INFO_SIZE, 2'h0, 32'h0000_2004);
        for (int i = 0; i < 4; i++) begin
            lfsr = step(lfsr);
            wr(OFS_CNT_BASE + 8'(4 * i), lfsr, 2'h0);
            rchk("count load", OFS_CNT_BASE + 8'(4 * i), 2'h0, lfsr);
            cv = (i == 0) ? 32'h0000_0203 : (i == 1) ? 32'h0000_0105 : {24'h00_0000, lfsr[15:8]};
            wr(OFS_CTL_BASE + 8'(4 * i), cv, 2'h0);
            rchk("control", OFS_CTL_BASE + 8'(4 * i), 2'h1, cv);
            if (i == 0) begin
                exp4 = lfsr;
            end
            if (i == 1) begin
                exp5 = lfsr;
            end
        end
        // refused writes above level zero
        wr(OFS_CTL_BASE, 32'h0000_0000, 2'h1);
        rchk("ctl4 kept", OFS_CTL_BASE, 2'h0, 32'h0000_0203);
        wr(OFS_CNT_BASE, 32'h1234_5678, 2'h2);
        check("hresp", {31'h0000_0000, hresp}, 32'h0000_0000);
        rchk("cnt4 kept", OFS_CNT_BASE, 2'h0, exp4);
        // both enables on but freeze low: nothing counts
        wr(OFS_PSW, 32'h0000_0003, 2'h0);
        up = 1'b1;
        pp = 1'b1;
        run_events(20);
        rchk("frozen cnt4", OFS_CNT_BASE, 2'h0, exp4);
        rchk("frozen cnt5", OFS_CNT_BASE + 8'h04, 2'h0, exp5);
        wr(OFS_GLOBAL, 32'h0000_0001, 2'h0);
        frz = 1'b1;
        wr(OFS_GLOBAL, 32'h0000_0000, 2'h1);
        rchk("freeze kept", OFS_GLOBAL, 2'h0, 32'h0000_0001);
        run_events(30);
        rchk("cnt4 both", OFS_CNT_BASE, 2'h0, exp4);
        rchk("cnt5 both", OFS_CNT_BASE + 8'h04, 2'h0, exp5);
        // a user-level write reaches only the user enable
        wr(OFS_PSW, 32'h0000_0000, 2'h3);
        up = 1'b0;
        rchk("psw user", OFS_PSW, 2'h0, 32'h0000_0002);
        run_events(30);
        rchk("cnt4 up off", OFS_CNT_BASE, 2'h0, exp4);
        rchk("cnt5 pp on", OFS_CNT_BASE + 8'h04, 2'h0, exp5);
        wr(OFS_PSW, 32'h0000_0001, 2'h0);
        up = 1'b1;
        pp = 1'b0;
        run_events(30);
        rchk("cnt4 up on", OFS_CNT_BASE, 2'h0, exp4);
        rchk("cnt5 pp off", OFS_CNT_BASE + 8'h04, 2'h0, exp5);
        // read protection
        rchk("priv read user", OFS_CNT_BASE + 8'h04, 2'h1, 32'h0000_0000);
        rchk("user read user", OFS_CNT_BASE, 2'h1, exp4);
        wr(OFS_PSW, 32'h0000_0005, 2'h0);
        rchk("blocked read", OFS_CNT_BASE, 2'h1, 32'h0000_0000);
        rchk("level0 read", OFS_CNT_BASE, 2'h0, exp4);
        // wrap at the maximum raises the overflow interrupt
        wr(OFS_IRQ_MASK, 32'h0000_00FF, 2'h0);
        wr(OFS_CNT_BASE, 32'hFFFF_FFFF, 2'h0);
        @(posedge hclk);
        event_in <= 16'h0008;
        @(posedge hclk);
        event_in <= 16'h0000;
        irq_chk(1'b1);
        rchk("wrapped", OFS_CNT_BASE, 2'h0, 32'h0000_0000);
        wr(OFS_IRQ_MASK, 32'h0000_0000, 2'h0);
        irq_chk(1'b0);
        wr(OFS_IRQ_MASK, 32'h0000_00FF, 2'h0);
        irq_chk(1'b1);
        wr(OFS_IRQ_STATUS, 32'h0000_00FF, 2'h1);
        irq_chk(1'b1);
        wr(OFS_IRQ_STATUS, 32'h0000_00FF, 2'h0);
        irq_chk(1'b0);
        // a reset in mid-run must bring counters and controls back to idle
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        irq_chk(1'b0);
        rchk("global rst", OFS_GLOBAL, 2'h0, 32'h0000_0000);
        rchk("cnt5 rst", OFS_CNT_BASE + 8'h04, 2'h0, 32'h0000_0000);
        rchk("ctl5 rst", OFS_CTL_BASE + 8'h04, 2'h0, 32'h0000_0000);
        conclude();
    end
endmodule : event_counter_monitor_tb
